//--- rtl/ilo_addr_gen.sv
`timescale 1ns/1ps
module ilo_addr_gen (
	input wire logic ext_en, // Extended set enabled
	input wire logic access_bit, // Operand access bit
	input wire logic [7:0] operand, // Short operand field
	input wire logic [ilo_pkg::ILO_DATA_AW-1:0] frame_ptr, // Frame pointer
	input wire logic [7:0] bank_sel, // Bank select value
	output logic [ilo_pkg::ILO_DATA_AW-1:0] eff_addr, // Effective address
	output logic indexed // Operand used as offset
);
	import ilo_pkg::*;

	logic [ILO_DATA_AW:0] sum;

	always_comb begin
		sum = {1'b0, frame_ptr} + {{(ILO_DATA_AW-7){1'b0}}, operand};
		// [RL1] Offset at or below limit.
		// [RL12] Access bit gates indexing.
		indexed = ext_en && !access_bit && (operand <= ILO_OFFSET_LIMIT);
		if (indexed) begin
			// [RL13] Truncated pointer sum.
			eff_addr = sum[ILO_DATA_AW-1:0];
		end else if (access_bit) begin
			eff_addr = {bank_sel[3:0], operand};
		end else if (operand >= ILO_ACCESS_HIGH) begin
			eff_addr = {ILO_ACCESS_SFR_PAGE, operand};
		end else begin
			eff_addr = {4'h0, operand};
		end
	end

endmodule : ilo_addr_gen

//--- rtl/ilo_alu.sv
`timescale 1ns/1ps
module ilo_alu (
	input wire ilo_pkg::ilo_op_t op, // Operation
	input wire logic [7:0] acc, // Accumulator value
	input wire logic [7:0] operand, // Data byte read
	input wire logic [2:0] bit_num, // Bit number for bit set
	output logic [7:0] result, // Operation result
	output logic [4:0] flags_out, // Flags from result
	output logic upd_flags // Flags are to be updated
);
	import ilo_pkg::*;

	logic [8:0] sum;
	logic [4:0] low;

	always_comb begin
		sum = {1'b0, acc} + {1'b0, operand};
		low = {1'b0, acc[3:0]} + {1'b0, operand[3:0]};
		flags_out = 5'h00;
		upd_flags = 1'b0;
		result = operand;
		unique case (op)
			ILO_OP_ADD: begin
				// [RL2] Accumulator plus byte.
				result = sum[7:0];
				// [RL4] Add status flags.
				upd_flags = 1'b1;
				flags_out[ILO_FLAG_C] = sum[8];
				flags_out[ILO_FLAG_DC] = low[4];
				flags_out[ILO_FLAG_Z] = (sum[7:0] == 8'h00);
				flags_out[ILO_FLAG_N] = sum[7];
				flags_out[ILO_FLAG_OV] = (acc[7] == operand[7]) &&
					(sum[7] != acc[7]);
			end
			ILO_OP_BSET: begin
				// [RL6] Set one bit.
				result = operand | (8'h01 << bit_num);
			end
			ILO_OP_FILL: begin
				// [RL8] Fill with ones.
				result = ILO_FILL_VALUE;
			end
			ILO_OP_NONE: begin
				result = operand;
			end
		endcase
	end

endmodule : ilo_alu

//--- rtl/ilo_core.sv
`timescale 1ns/1ps
// What this block does
// [RL1] With the extended set on, an access operand of 5Fh or less is an offset from the frame pointer.
// [RL2] The indexed add sums the accumulator with the byte at frame pointer plus offset 0 to 95.
// [RL3] The add writes the accumulator when the destination bit is 0 and the byte when it is 1.
// [RL4] The add updates the negative, overflow, carry, half carry and zero flags.
// [RL5] The add is decoded from top bits 0010 01, destination, access 0, then an 8-bit offset.
// [RL6] The bit set sets bit 0 to 7 of the indexed byte and leaves the flags alone.
// [RL7] The bit set is decoded from top bits 1000, a 3-bit bit number, access 0, then the offset.
// [RL8] The fill writes FFh into the indexed byte and leaves the flags alone.
// [RL9] The fill is decoded from upper byte 0110 1000 followed by the offset.
// [RL10] Each instruction takes one instruction cycle of decode, read, process and write phases.
// [RL11] With the configuration bit at 0 the extended set and indexing are both off.
// [RL12] Indexing applies only with access bit 0; with access bit 1 the bank select picks the bank.
// [RL13] The address is the frame pointer plus the zero-extended offset, and writes go there too.
module ilo_core (
	input wire logic clk_sys, // System clock, 20 MHz
	input wire logic srst, // Synchronous reset, active high
	input wire logic [ilo_pkg::ILO_REG_AW-1:0] reg_addr, // Register address
	input wire logic [7:0] reg_wdata, // Register write data
	input wire logic reg_wr, // Register write strobe
	input wire logic reg_rd, // Register read strobe
	output logic [7:0] reg_rdata, // Read data, cycle after strobe
	output logic [ilo_pkg::ILO_DATA_AW-1:0] mem_addr, // Data address
	output logic mem_re, // Data read strobe
	input wire logic [7:0] mem_rdata, // Data byte, cycle after strobe
	output logic [7:0] mem_wdata, // Data write byte
	output logic mem_we, // Data write strobe
	output logic busy // Instruction in progress
);
	import ilo_pkg::*;

	// ==========================================================
	// State
	// ==========================================================
	typedef struct packed {
		ilo_phase_t phase;
		logic ext_en;
		logic [15:0] opcode;
		logic [7:0] acc;
		logic [4:0] flags;
		logic [ILO_DATA_AW-1:0] fp;
		logic [7:0] bank;
		ilo_op_t op;
		logic dest_acc;
		logic [2:0] bit_num;
		logic [ILO_DATA_AW-1:0] ea;
		logic indexed;
		logic bad_op;
		logic [7:0] operand;
		logic [7:0] result;
		logic [4:0] res_flags;
		logic upd_flags;
		logic [ILO_DATA_AW-1:0] mem_addr;
		logic mem_re;
		logic [7:0] mem_wdata;
		logic mem_we;
		logic [7:0] rdata;
		logic busy;
	} ilo_core_state_t;

	ilo_core_state_t s;
	ilo_core_state_t next_s;

	logic [ILO_DATA_AW-1:0] gen_addr;
	logic gen_indexed;
	logic [7:0] alu_result;
	logic [4:0] alu_flags;
	logic alu_upd;
	logic [7:0] read_mux;

	// ==========================================================
	// Address and operation units
	// ==========================================================
	ilo_addr_gen u_addr (
		.ext_en(s.ext_en),
		.access_bit(s.opcode[ILO_OPC_ACCESS_BIT]),
		.operand(s.opcode[7:0]),
		.frame_ptr(s.fp),
		.bank_sel(s.bank),
		.eff_addr(gen_addr),
		.indexed(gen_indexed)
	);

	// The byte reaches the data port only in the process phase, so the
	// operation unit takes it straight from the port.
	ilo_alu u_alu (
		.op(s.op),
		.acc(s.acc),
		.operand(mem_rdata),
		.bit_num(s.bit_num),
		.result(alu_result),
		.flags_out(alu_flags),
		.upd_flags(alu_upd)
	);

	// ==========================================================
	// Register read mux
	// ==========================================================
	always_comb begin
		read_mux = 8'h00;
		unique case (reg_addr)
			ILO_OFS_CTRL: read_mux[ILO_CTRL_EXT_BIT] = s.ext_en;
			ILO_OFS_OPC_LO: read_mux = s.opcode[7:0];
			ILO_OFS_OPC_HI: read_mux = s.opcode[15:8];
			ILO_OFS_ACC: read_mux = s.acc;
			ILO_OFS_FLAGS: read_mux = {3'h0, s.flags};
			ILO_OFS_FP_LO: read_mux = s.fp[7:0];
			ILO_OFS_FP_HI: read_mux = {4'h0, s.fp[11:8]};
			ILO_OFS_BANK: read_mux = s.bank;
			ILO_OFS_STATE: begin
				read_mux[ILO_ST_BUSY] = s.busy;
				read_mux[ILO_ST_INDEXED] = s.indexed;
				read_mux[ILO_ST_BAD_OP] = s.bad_op;
			end
			default: read_mux = 8'h00;
		endcase
	end

	// ==========================================================
	// Next state
	// ==========================================================
	always_comb begin
		next_s = s;
		next_s.mem_re = 1'b0;
		next_s.mem_we = 1'b0;
		if (reg_rd) begin
			next_s.rdata = read_mux;
		end
		// Software writes are dropped while an instruction runs, so
		// the operands cannot change under the sequencer.
		if (reg_wr && s.phase == ILO_PH_IDLE) begin
			unique case (reg_addr)
				ILO_OFS_CTRL: begin
					// [RL11] Extended set enable.
					next_s.ext_en = reg_wdata[ILO_CTRL_EXT_BIT];
				end
				ILO_OFS_OPC_LO: next_s.opcode[7:0] = reg_wdata;
				ILO_OFS_OPC_HI: begin
					next_s.opcode[15:8] = reg_wdata;
					next_s.phase = ILO_PH_DECODE;
					next_s.busy = 1'b1;
				end
				ILO_OFS_ACC: next_s.acc = reg_wdata;
				ILO_OFS_FLAGS: next_s.flags = reg_wdata[4:0];
				ILO_OFS_FP_LO: next_s.fp[7:0] = reg_wdata;
				ILO_OFS_FP_HI: next_s.fp[11:8] = reg_wdata[3:0];
				ILO_OFS_BANK: next_s.bank = reg_wdata;
				default: next_s.bank = s.bank;
			endcase
		end
		// [RL10] Four phase sequence.
		unique case (s.phase)
			ILO_PH_IDLE: begin
				next_s.bad_op = s.bad_op;
			end
			ILO_PH_DECODE: begin
				next_s.op = ILO_OP_NONE;
				next_s.bad_op = 1'b0;
				next_s.dest_acc = !s.opcode[ILO_OPC_DEST_BIT];
				next_s.bit_num = s.opcode[11:9];
				if (s.opcode[15:10] == ILO_OPC_ADD) begin
					// [RL5] Add encoding.
					next_s.op = ILO_OP_ADD;
				end else if (s.opcode[15:12] == ILO_OPC_BSET) begin
					// [RL7] Bit set encoding.
					next_s.op = ILO_OP_BSET;
				end else if (s.opcode[15:9] == ILO_OPC_FILL) begin
					// [RL9] Fill encoding.
					next_s.op = ILO_OP_FILL;
				end else begin
					next_s.bad_op = 1'b1;
				end
				next_s.ea = gen_addr;
				next_s.indexed = gen_indexed;
				next_s.mem_addr = gen_addr;
				next_s.mem_re = 1'b1;
				next_s.phase = ILO_PH_READ;
			end
			ILO_PH_READ: begin
				// The memory answers one cycle after the strobe, so
				// there is nothing to take yet.
				next_s.phase = ILO_PH_PROC;
			end
			ILO_PH_PROC: begin
				next_s.operand = mem_rdata;
				next_s.result = alu_result;
				next_s.res_flags = alu_flags;
				next_s.upd_flags = alu_upd;
				next_s.mem_wdata = alu_result;
				// [RL3] Destination select.
				// [RL13] Write back to same address.
				next_s.mem_we = (s.op != ILO_OP_NONE) &&
					!(s.op == ILO_OP_ADD && s.dest_acc);
				next_s.mem_addr = s.ea;
				next_s.phase = ILO_PH_WRITE;
			end
			ILO_PH_WRITE: begin
				if (s.op == ILO_OP_ADD && s.dest_acc) begin
					next_s.acc = s.result;
				end
				// [RL4] Commit add flags.
				if (s.upd_flags) begin
					next_s.flags = s.res_flags;
				end
				next_s.upd_flags = 1'b0;
				next_s.busy = 1'b0;
				next_s.phase = ILO_PH_IDLE;
			end
			default: begin
				next_s.busy = 1'b0;
				next_s.phase = ILO_PH_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			s <= '0;
			s.phase <= ILO_PH_IDLE;
			s.op <= ILO_OP_NONE;
			s.ext_en <= ILO_RST_EXT;
			s.acc <= ILO_RST_ACC;
			s.flags <= ILO_RST_FLAGS;
			s.fp <= ILO_RST_FP;
			s.bank <= ILO_RST_BANK;
		end else begin
			s <= next_s;
		end
	end

	assign reg_rdata = s.rdata;
	assign mem_addr = s.mem_addr;
	assign mem_re = s.mem_re;
	assign mem_wdata = s.mem_wdata;
	assign mem_we = s.mem_we;
	assign busy = s.busy;

	// ==========================================================
	// Checks
	// ==========================================================
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (srst);

	a_four_phase_run: assert property ( // [RL10]
		s.phase == ILO_PH_DECODE |=> s.phase == ILO_PH_READ ##1
		s.phase == ILO_PH_PROC ##1 s.phase == ILO_PH_WRITE ##1
		s.phase == ILO_PH_IDLE && !busy)
		else $error("instruction did not finish in four phases");

	a_index_address: assert property ( // [RL1]
		s.phase == ILO_PH_READ && s.indexed |->
		mem_addr == 12'(s.fp + {4'h0, s.opcode[7:0]}) &&
		s.opcode[7:0] <= ILO_OFFSET_LIMIT)
		else $error("indexed address is not pointer plus offset");

	a_ext_off_abs: assert property ( // [RL11]
		s.phase == ILO_PH_READ && !s.ext_en |-> !s.indexed)
		else $error("indexing used with extended set off");

	a_bank_access: assert property ( // [RL12]
		s.phase == ILO_PH_READ && s.opcode[ILO_OPC_ACCESS_BIT] |->
		!s.indexed && mem_addr[11:8] == s.bank[3:0])
		else $error("access bit set but bank not used");

	a_add_to_acc: assert property ( // [RL3]
		s.phase == ILO_PH_PROC && s.op == ILO_OP_ADD && s.dest_acc |=>
		!mem_we ##1 s.acc == 8'($past(s.acc, 2) + s.operand))
		else $error("add to accumulator wrong or wrote memory");

	a_add_write_back: assert property ( // [RL2]
		s.phase == ILO_PH_WRITE && s.op == ILO_OP_ADD && !s.dest_acc |->
		mem_we && mem_wdata == 8'(s.acc + s.operand) && mem_addr == s.ea)
		else $error("add write back wrong");

	a_add_zero_flag: assert property ( // [RL4]
		s.phase == ILO_PH_WRITE && s.op == ILO_OP_ADD |=>
		s.flags[ILO_FLAG_Z] == ($past(s.result) == 8'h00) &&
		s.flags[ILO_FLAG_C] == $past(s.res_flags[ILO_FLAG_C]))
		else $error("add flags not committed");

	a_bit_set_data: assert property ( // [RL6]
		mem_we && s.op == ILO_OP_BSET |->
		mem_wdata == (s.operand | (8'h01 << s.bit_num)))
		else $error("bit set data wrong");

	a_keep_flags: assert property ( // [RL8]
		s.phase == ILO_PH_WRITE && s.op != ILO_OP_ADD |=>
		$stable(s.flags) && (s.op != ILO_OP_FILL ||
		$past(mem_wdata) == ILO_FILL_VALUE))
		else $error("flags changed or fill value wrong");

	a_decode_add: assert property ( // [RL5]
		s.phase == ILO_PH_DECODE && s.opcode[15:10] == 6'h09 |=>
		s.op == ILO_OP_ADD)
		else $error("add opcode not decoded");

	a_decode_bset: assert property ( // [RL7]
		s.phase == ILO_PH_DECODE && s.opcode[15:12] == 4'h8 |=>
		s.op == ILO_OP_BSET && s.bit_num == s.opcode[11:9])
		else $error("bit set opcode not decoded");

	a_decode_fill: assert property ( // [RL9]
		s.phase == ILO_PH_DECODE && s.opcode[15:8] == 8'h68 |=>
		s.op == ILO_OP_FILL)
		else $error("fill opcode not decoded");

	a_read_strobe: assert property ( // [RL10]
		mem_re |-> s.phase == ILO_PH_READ && mem_addr == s.ea)
		else $error("data read outside the read phase");

	a_write_target: assert property ( // [RL13]
		mem_we |-> s.phase == ILO_PH_WRITE && mem_addr == s.ea)
		else $error("data write outside the write phase or address");

	a_half_carry: assert property ( // [RL4]
		s.phase == ILO_PH_WRITE && s.op == ILO_OP_ADD |=>
		s.flags[ILO_FLAG_DC] == (({1'b0, $past(s.acc[3:0])} +
		{1'b0, s.operand[3:0]}) > 5'h0F))
		else $error("half carry flag wrong");

	a_sign_wrap: assert property ( // [RL4]
		s.phase == ILO_PH_WRITE && s.op == ILO_OP_ADD |=>
		s.flags[ILO_FLAG_OV] == ($past(s.acc[7]) == s.operand[7] &&
		s.result[7] != s.operand[7]))
		else $error("sign wrap flag wrong");

	a_negative_flag: assert property ( // [RL4]
		s.phase == ILO_PH_WRITE && s.op == ILO_OP_ADD |=>
		s.flags[ILO_FLAG_N] == s.result[7])
		else $error("negative flag wrong");

	a_bad_op_quiet: assert property ( // [RL5]
		s.phase == ILO_PH_PROC && s.op == ILO_OP_NONE |=> !mem_we)
		else $error("unsupported opcode wrote memory");

	a_ext_on_index: assert property ( // [RL1]
		s.phase == ILO_PH_READ && s.ext_en &&
		!s.opcode[ILO_OPC_ACCESS_BIT] && s.opcode[7:0] <= 8'h5F |->
		s.indexed)
		else $error("short operand not used as offset");

	a_launch_busy: assert property ( // [RL10]
		s.phase == ILO_PH_IDLE && reg_wr &&
		reg_addr == ILO_OFS_OPC_HI |=>
		busy && s.phase == ILO_PH_DECODE)
		else $error("opcode write did not start the sequence");

	a_absolute_low: assert property ( // [RL12]
		s.phase == ILO_PH_READ && !s.indexed |->
		mem_addr[7:0] == s.opcode[7:0])
		else $error("absolute address low byte wrong");

endmodule : ilo_core

//--- rtl/ilo_pkg.sv
package ilo_pkg;

	// ==========================================================
	// Widths
	// ==========================================================
	localparam int ILO_DATA_AW = 12;
	localparam int ILO_REG_AW = 4;

	// ==========================================================
	// Register offsets
	// ==========================================================
	localparam logic [3:0] ILO_OFS_CTRL = 4'h0;
	localparam logic [3:0] ILO_OFS_OPC_LO = 4'h1;
	localparam logic [3:0] ILO_OFS_OPC_HI = 4'h2;
	localparam logic [3:0] ILO_OFS_ACC = 4'h3;
	localparam logic [3:0] ILO_OFS_FLAGS = 4'h4;
	localparam logic [3:0] ILO_OFS_FP_LO = 4'h5;
	localparam logic [3:0] ILO_OFS_FP_HI = 4'h6;
	localparam logic [3:0] ILO_OFS_BANK = 4'h7;
	localparam logic [3:0] ILO_OFS_STATE = 4'h8;

	// ==========================================================
	// Field positions
	// ==========================================================
	localparam int ILO_CTRL_EXT_BIT = 0;
	localparam int ILO_FLAG_C = 0;
	localparam int ILO_FLAG_DC = 1;
	localparam int ILO_FLAG_Z = 2;
	localparam int ILO_FLAG_OV = 3;
	localparam int ILO_FLAG_N = 4;
	localparam int ILO_ST_BUSY = 0;
	localparam int ILO_ST_INDEXED = 1;
	localparam int ILO_ST_BAD_OP = 2;
	localparam int ILO_OPC_ACCESS_BIT = 8;
	localparam int ILO_OPC_DEST_BIT = 9;

	// ==========================================================
	// Reset values
	// ==========================================================
	localparam logic ILO_RST_EXT = 1'b0;
	localparam logic [7:0] ILO_RST_ACC = 8'h00;
	localparam logic [4:0] ILO_RST_FLAGS = 5'h00;
	localparam logic [11:0] ILO_RST_FP = 12'h000;
	localparam logic [7:0] ILO_RST_BANK = 8'h00;

	// ==========================================================
	// Encodings and constants
	// ==========================================================
	localparam logic [7:0] ILO_OFFSET_LIMIT = 8'h5F;
	localparam logic [7:0] ILO_ACCESS_HIGH = 8'h80;
	localparam logic [3:0] ILO_ACCESS_SFR_PAGE = 4'hF;
	localparam logic [7:0] ILO_FILL_VALUE = 8'hFF;
	localparam logic [5:0] ILO_OPC_ADD = 6'h09;
	localparam logic [3:0] ILO_OPC_BSET = 4'h8;
	localparam logic [6:0] ILO_OPC_FILL = 7'h34;

	typedef enum logic [1:0] {
		ILO_OP_NONE = 2'b00,
		ILO_OP_ADD = 2'b01,
		ILO_OP_BSET = 2'b10,
		ILO_OP_FILL = 2'b11
	} ilo_op_t;

	typedef enum logic [2:0] {
		ILO_PH_IDLE = 3'b000,
		ILO_PH_DECODE = 3'b001,
		ILO_PH_READ = 3'b010,
		ILO_PH_PROC = 3'b011,
		ILO_PH_WRITE = 3'b100
	} ilo_phase_t;

endpackage : ilo_pkg

//--- verif/indexed_literal_offset_exec_tb.sv
`timescale 1ns/1ps
module indexed_literal_offset_exec_tb;
	import ilo_pkg::*;

	typedef struct {
		logic [11:0] fp;
		logic [15:0] opc;
		logic [7:0] acc;
		logic [7:0] mval;
		logic [4:0] flg;
		logic [11:0] ea;
		logic [7:0] res;
		logic [4:0] eflg;
	} ilo_row_t;

	logic clk_sys = 1'b0;
	logic srst = 1'b1;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	logic [11:0] mem_addr;
	logic mem_re;
	logic [7:0] mem_rdata = 8'h00;
	logic [7:0] mem_wdata;
	logic mem_we;
	logic busy;
	logic [7:0] mem [4096];
	logic [11:0] rd_at;
	logic [11:0] wr_at;
	logic [3:0] rst_ofs [6];
	int busy_cyc;
	int rd_cnt;
	int wr_cnt;
	int err_count = 0;
	int total_checks = 0;
	ilo_row_t rows [11];

	always #25 clk_sys = ~clk_sys;

	ilo_core DUT (.clk_sys(clk_sys), .srst(srst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .mem_addr(mem_addr), .mem_re(mem_re),
		.mem_rdata(mem_rdata), .mem_wdata(mem_wdata), .mem_we(mem_we),
		.busy(busy));

	// ==========================================================
	// Data memory and activity monitor
	// ==========================================================
	// Outside the answer cycle the data bus toggles, so a sample taken
	// one cycle late can never match the stored byte by chance.
	always @(posedge clk_sys) begin
		mem_rdata <= (mem_re === 1'b1) ? mem[mem_addr] : ~mem_rdata;
		if (busy === 1'b1)
			busy_cyc++;
		if (mem_re === 1'b1) begin
			rd_cnt++;
			rd_at <= mem_addr;
		end
		if (mem_we === 1'b1) begin
			wr_cnt++;
			wr_at <= mem_addr;
			mem[mem_addr] <= mem_wdata;
		end
	end

	// ==========================================================
	// Compare and bus tasks
	// ==========================================================
	task automatic chk_v(input logic [11:0] got, input logic [11:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch at %0t: value %h, want %h", $time, got, exp);
		end
	endtask : chk_v

	task automatic chk_n(input int got, input int exp);
		total_checks++;
		if (got != exp) begin
			err_count++;
			$display("mismatch at %0t: count %0d, want %0d", $time, got, exp);
		end
	endtask : chk_n

	task automatic end_sim();
		$display("checks %0d, errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : end_sim

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		@(posedge clk_sys);
	endtask : wr

	task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
		logic [7:0] d;
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
		chk_v({4'h0, d}, {4'h0, exp});
		@(posedge clk_sys);
	endtask : rd_chk

	task automatic launch(input ilo_row_t r);
		wr(ILO_OFS_FP_LO, r.fp[7:0]);
		wr(ILO_OFS_FP_HI, {4'h0, r.fp[11:8]});
		wr(ILO_OFS_ACC, r.acc);
		wr(ILO_OFS_FLAGS, {3'h0, r.flg});
		mem[r.ea] = r.mval;
		busy_cyc = 0;
		rd_cnt = 0;
		wr_cnt = 0;
		wr(ILO_OFS_OPC_LO, r.opc[7:0]);
		wr(ILO_OFS_OPC_HI, r.opc[15:8]);
	endtask : launch

	task automatic finish(input ilo_row_t r);
		int i;
		logic to_acc;
		i = 0;
		to_acc = (r.opc[15:10] == ILO_OPC_ADD) && !r.opc[ILO_OPC_DEST_BIT];
		while (busy !== 1'b0) begin
			@(posedge clk_sys);
			i++;
			if (i > 20) begin
				err_count++;
				$display("mismatch at %0t: busy never cleared", $time);
				end_sim();
			end
		end
		chk_n(busy_cyc, 4);
		chk_n(rd_cnt, 1);
		chk_v(rd_at, r.ea);
		chk_n(wr_cnt, to_acc ? 0 : 1);
		if (!to_acc)
			chk_v(wr_at, r.ea);
		chk_v({4'h0, to_acc ? r.mval : r.res}, {4'h0, mem[r.ea]});
		rd_chk(ILO_OFS_ACC, to_acc ? r.res : r.acc);
		rd_chk(ILO_OFS_FLAGS, {3'h0, r.eflg});
	endtask : finish

	// ==========================================================
	// Main sequence
	// ==========================================================
	initial begin
		rows[0] = '{12'hA00,16'h242C,8'h17,8'h20,5'h00,12'hA2C,8'h37,5'h00};
		rows[1] = '{12'hA00,16'h265F,8'h80,8'h80,5'h00,12'hA5F,8'h00,5'h0D};
		rows[2] = '{12'hFF0,16'h2650,8'h7F,8'h01,5'h05,12'h040,8'h80,5'h1A};
		rows[3] = '{12'hA00,16'h8E0A,8'h00,8'h55,5'h1F,12'hA0A,8'hD5,5'h1F};
		rows[4] = '{12'h123,16'h8001,8'h00,8'hFE,5'h0A,12'h124,8'hFF,5'h0A};
		rows[5] = '{12'hA00,16'h682C,8'h00,8'h00,5'h15,12'hA2C,8'hFF,5'h15};
		rows[6] = '{12'hA00,16'h272C,8'h01,8'h02,5'h00,12'h52C,8'h03,5'h00};
		rows[7] = '{12'hA00,16'h6860,8'h00,8'h00,5'h00,12'h060,8'hFF,5'h00};
		rows[8] = '{12'hA00,16'h8710,8'h00,8'h00,5'h11,12'h510,8'h08,5'h11};
		rows[9] = '{12'h000,16'h2400,8'hFF,8'h01,5'h00,12'h000,8'h00,5'h07};
		rows[10] = '{12'hA00,16'h262C,8'h01,8'h02,5'h00,12'h02C,8'h03,5'h00};
		rst_ofs = '{ILO_OFS_CTRL, ILO_OFS_ACC, ILO_OFS_FLAGS, ILO_OFS_FP_LO,
			ILO_OFS_FP_HI, ILO_OFS_BANK};
		foreach (mem[i])
			mem[i] = 8'hC3;
		repeat (2) @(posedge clk_sys);
		srst <= 1'b0;
		@(posedge clk_sys);
		wr(ILO_OFS_CTRL, 8'h01);
		wr(ILO_OFS_BANK, 8'h05);
		for (int n = 0; n < 10; n++) begin
			launch(rows[n]);
			finish(rows[n]);
		end
		rd_chk(ILO_OFS_STATE, 8'h02);
		// An opcode outside the three forms runs but writes nothing.
		wr_cnt = 0;
		wr(ILO_OFS_OPC_LO, 8'h00);
		wr(ILO_OFS_OPC_HI, 8'hFF);
		repeat (4) @(posedge clk_sys);
		chk_n(wr_cnt, 0);
		rd_chk(ILO_OFS_STATE, 8'h04);
		rd_chk(ILO_OFS_FLAGS, 8'h07);
		// A write that lands while busy must leave the accumulator alone.
		launch(rows[5]);
		wr(ILO_OFS_ACC, 8'h99);
		finish(rows[5]);
		rd_chk(4'hF, 8'h00);
		// Reset in mid-instruction: nothing may be written.
		launch(rows[2]);
		srst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		chk_v({11'h000, busy}, 12'h000);
		chk_v({11'h000, mem_we}, 12'h000);
		chk_n(wr_cnt, 0);
		srst <= 1'b0;
		@(posedge clk_sys);
		foreach (rst_ofs[i])
			rd_chk(rst_ofs[i], 8'h00);
		// Configuration bit is back at zero, so the offset is an address.
		launch(rows[10]);
		finish(rows[10]);
		end_sim();
	end

endmodule : indexed_literal_offset_exec_tb
